// ===== hdl/mcis_pkg.sv
// Package: opcodes, flag layout, reset values and structs of the instruction subset core
package mcis_pkg;

  localparam int FILE_ADDR_W = 7;
  localparam int DATA_W      = 8;
  localparam int FILE_DEPTH  = 128;

  // Operand codes of the direction load
  localparam logic [2:0] DIR_SEL_A = 3'h5;
  localparam logic [2:0] DIR_SEL_B = 3'h6;
  localparam logic [2:0] DIR_SEL_C = 3'h7;

  // Destination select values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Reset, sleep entry and watchdog values
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'hFF;
  localparam logic [7:0] WDT_CLR_VAL  = 8'h00;
  localparam logic [7:0] PRESC_CLR    = 8'h00;
  localparam logic       TO_N_RST     = 1'b1;
  localparam logic       PD_N_RST     = 1'b1;
  localparam logic       TO_N_SLEEP   = 1'b1;
  localparam logic       PD_N_SLEEP   = 1'b0;
  localparam logic       WDT_TIMEOUT_N = 1'b0;
  localparam logic [7:0] WDT_LAST     = 8'hFF;
  localparam logic [7:0] FILE_RST     = 8'h00;

  typedef enum logic [3:0] {
    MCIS_OP_NOP,
    MCIS_OP_ROTATE_RIGHT_VIA_CARRY,
    MCIS_OP_LITERAL_MINUS_ACC,
    MCIS_OP_SLEEP,
    MCIS_OP_FILE_MINUS_ACC,
    MCIS_OP_FILE_MINUS_ACC_BORROW,
    MCIS_OP_NIBBLE_EXCHANGE,
    MCIS_OP_LOAD_PORT_DIRECTION,
    MCIS_OP_XOR_LITERAL_ACC,
    MCIS_OP_XOR_ACC_FILE
  } mcis_op_t;

  typedef struct packed {
    logic                   valid;
    mcis_op_t               op;
    logic [FILE_ADDR_W-1:0] addr;
    logic                   dest;
    logic [DATA_W-1:0]      literal;
  } mcis_instr_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } mcis_flags_t;

  typedef struct packed {
    logic [DATA_W-1:0] port_a_direction;
    logic [DATA_W-1:0] port_b_direction;
    logic [DATA_W-1:0] port_c_direction;
  } mcis_dirs_t;

endpackage : mcis_pkg

// ===== hdl/mcis_file_ram.sv
// File register memory with registered read data
`timescale 1ns/10ps
module mcis_file_ram
  import mcis_pkg::*;
(
  input  wire logic                   clk_sys_i,  // Core clock
  input  wire logic                   rst_n_i,    // Reset, active low
  input  wire logic [FILE_ADDR_W-1:0] rd_addr_i,  // Read address
  output logic      [DATA_W-1:0]      rd_data_o,  // Registered read data
  input  wire logic                   wr_en_i,    // Write strobe
  input  wire logic [FILE_ADDR_W-1:0] wr_addr_i,  // Write address
  input  wire logic [DATA_W-1:0]      wr_data_i   // Write data
);

  logic [DATA_W-1:0] mem_q [FILE_DEPTH];

  // Cleared on reset: every file instruction reads before it writes, so
  // unknown words could never be brought to a known value
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        mem_q[i] <= FILE_RST;
      end
      rd_data_o <= FILE_RST;
    end else begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule : mcis_file_ram

// ===== hdl/mcis_core.sv
// Execution core for a rotate, subtract, sleep, swap, direction and xor instruction subset
// Operation
// - Rotate file right through carry
// - Destination bit picks accumulator or file
// - Literal minus accumulator into accumulator
// - Carry and half carry mean no borrow
// - Sleep clears watchdog, sets timeout, clears powerdown
// - Sleep halts the oscillator
// - File minus accumulator, routed, flags updated
// - Subtract with borrow, borrow is inverted carry
// - Nibble exchange, no flags changed
// - Accumulator loads port direction 5, 6, 7
// - Xor literal into accumulator, zero only
// - Xor file, routed, zero only
`timescale 1ns/10ps
module mcis_core
  import mcis_pkg::*;
(
  input  wire logic        clk_sys_i,    // Core clock, 20 MHz
  input  wire logic        arst_n_i,     // Asynchronous reset, active low
  input  wire mcis_instr_t instr_i,      // Instruction to execute
  output logic             instr_rdy_o,  // Core can take an instruction
  input  wire logic        wake_i,       // Wake request, from a pin
  input  wire logic        wdt_tick_i,   // Watchdog prescaler tick
  output logic [7:0]       acc_o,        // Accumulator
  output mcis_flags_t      flags_o,      // Status flags
  output mcis_dirs_t       dirs_o,       // Port direction registers
  output logic [7:0]       wdt_count_o,  // Watchdog counter
  output logic             osc_run_o,    // Oscillator enable, low in sleep
  output logic             done_o        // Instruction retired pulse
);
  import mcis_pkg::*;

  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  logic wake_meta_q;
  logic wake_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_meta_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      wake_meta_q <= wake_i;
      wake_q      <= wake_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  // Returns {carry, half carry, difference}; carry high means no borrow
  function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic borrow);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, borrow};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow};
    sub_flags = {~full[8], ~low[4], full[7:0]};
  endfunction : sub_flags

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SLEEP} mcis_state_t;

  typedef struct packed {
    mcis_state_t state;
    mcis_instr_t ins;
    logic [7:0]  acc;
    mcis_flags_t flags;
    mcis_dirs_t  dirs;
    logic [7:0]  wdt;
    logic [7:0]  presc;
    logic        done;
  } mcis_core_t;

  mcis_core_t s_q;
  mcis_core_t s_d;

  logic [7:0] file_rd;
  logic       file_we;
  logic [7:0] file_wd;
  logic [7:0] res;
  logic [9:0] sub_r;
  logic       wr_res;

  mcis_file_ram u_file_ram (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .rd_addr_i (instr_i.addr),
    .rd_data_o (file_rd),
    .wr_en_i   (file_we),
    .wr_addr_i (s_q.ins.addr),
    .wr_data_i (file_wd)
  );

  assign instr_rdy_o = (s_q.state == ST_IDLE);

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    res      = file_rd;
    sub_r    = 10'h000;
    wr_res   = 1'b0;
    file_we  = 1'b0;
    file_wd  = 8'h00;
    // Watchdog runs while awake; sleep keeps it cleared
    if (s_q.state != ST_SLEEP && wdt_tick_i) begin
      s_d.wdt = s_q.wdt + 8'h01;
      if (s_q.wdt == WDT_LAST) begin
        s_d.flags.timeout_flag_n = WDT_TIMEOUT_N;
      end
    end
    unique case (s_q.state)
      ST_IDLE: begin
        if (instr_i.valid) begin
          // Hold operands while the file read completes
          s_d.ins   = instr_i;
          s_d.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_d.state = ST_IDLE;
        s_d.done  = 1'b1;
        unique case (s_q.ins.op)
          MCIS_OP_ROTATE_RIGHT_VIA_CARRY: begin
            res            = {s_q.flags.carry, file_rd[7:1]};
            s_d.flags.carry = file_rd[0];
            wr_res         = 1'b1;
          end
          MCIS_OP_LITERAL_MINUS_ACC: begin
            sub_r   = sub_flags(s_q.ins.literal, s_q.acc, 1'b0);
            res     = sub_r[7:0];
            s_d.acc = res;
            s_d.flags.carry           = sub_r[9];
            s_d.flags.half_carry_flag = sub_r[8];
            s_d.flags.zero            = is_zero(res);
          end
          MCIS_OP_FILE_MINUS_ACC,
          MCIS_OP_FILE_MINUS_ACC_BORROW: begin
            // Borrow is the inverted carry
            sub_r = sub_flags(file_rd, s_q.acc,
                              (s_q.ins.op == MCIS_OP_FILE_MINUS_ACC_BORROW) &
                              ~s_q.flags.carry);
            res    = sub_r[7:0];
            wr_res = 1'b1;
            s_d.flags.carry           = sub_r[9];
            s_d.flags.half_carry_flag = sub_r[8];
            s_d.flags.zero            = is_zero(res);
          end
          MCIS_OP_NIBBLE_EXCHANGE: begin
            res    = {file_rd[3:0], file_rd[7:4]};
            wr_res = 1'b1;
          end
          MCIS_OP_LOAD_PORT_DIRECTION: begin
            // Other operand values are ignored
            if (s_q.ins.addr[2:0] == DIR_SEL_A && s_q.ins.addr[6:3] == 4'h0) begin
              s_d.dirs.port_a_direction = s_q.acc;
            end
            if (s_q.ins.addr[2:0] == DIR_SEL_B && s_q.ins.addr[6:3] == 4'h0) begin
              s_d.dirs.port_b_direction = s_q.acc;
            end
            if (s_q.ins.addr[2:0] == DIR_SEL_C && s_q.ins.addr[6:3] == 4'h0) begin
              s_d.dirs.port_c_direction = s_q.acc;
            end
          end
          MCIS_OP_XOR_LITERAL_ACC: begin
            res            = s_q.acc ^ s_q.ins.literal;
            s_d.acc        = res;
            s_d.flags.zero = is_zero(res);
          end
          MCIS_OP_XOR_ACC_FILE: begin
            res            = s_q.acc ^ file_rd;
            wr_res         = 1'b1;
            s_d.flags.zero = is_zero(res);
          end
          MCIS_OP_SLEEP: begin
            s_d.wdt   = WDT_CLR_VAL;
            s_d.presc = PRESC_CLR;
            s_d.flags.timeout_flag_n   = TO_N_SLEEP;
            s_d.flags.powerdown_flag_n = PD_N_SLEEP;
            s_d.state = ST_SLEEP;
          end
          default: begin
          end
        endcase
        if (wr_res) begin
          if (s_q.ins.dest == DEST_ACC) begin
            s_d.acc = res;
          end else begin
            file_we = 1'b1;
            file_wd = res;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_q) begin
          s_d.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q.state <= ST_IDLE;
      s_q.ins   <= '0;
      s_q.acc   <= ACC_RST;
      s_q.flags <= '{carry: 1'b0, half_carry_flag: 1'b0, zero: 1'b0,
                     timeout_flag_n: TO_N_RST, powerdown_flag_n: PD_N_RST};
      s_q.dirs  <= '{DIR_RST, DIR_RST, DIR_RST};
      s_q.wdt   <= WDT_CLR_VAL;
      s_q.presc <= PRESC_CLR;
      s_q.done  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign acc_o       = s_q.acc;
  assign flags_o     = s_q.flags;
  assign dirs_o      = s_q.dirs;
  assign wdt_count_o = s_q.wdt;
  assign osc_run_o   = (s_q.state != ST_SLEEP);
  assign done_o      = s_q.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic exec_c;
  assign exec_c = (s_q.state == ST_EXEC);

  sequence s_exec(mcis_op_t o);
    exec_c && s_q.ins.op == o;
  endsequence

  sequence s_exec_addr(mcis_op_t o, logic [FILE_ADDR_W-1:0] f);
    exec_c && s_q.ins.op == o && s_q.ins.addr == f;
  endsequence

  property p_rotate;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      s_exec(MCIS_OP_ROTATE_RIGHT_VIA_CARRY) |=> s_q.flags.carry == $past(file_rd[0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

  property p_dest_acc;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      exec_c && wr_res && s_q.ins.dest == DEST_ACC |=> acc_o == $past(res);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("result not in accumulator");

  property p_dest_file;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      exec_c && wr_res && s_q.ins.dest == DEST_FILE |-> file_we ##1 acc_o == $past(acc_o);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file not written");

  property p_literal_sub;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      s_exec(MCIS_OP_LITERAL_MINUS_ACC) |=>
        acc_o == $past(s_q.ins.literal) - $past(s_q.acc) &&
        flags_o.carry == ($past(s_q.acc) <= $past(s_q.ins.literal));
  endproperty
  a_literal_sub: assert property (p_literal_sub) else $error("literal subtract wrong");

  property p_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      s_exec(MCIS_OP_SLEEP) |=> wdt_count_o == WDT_CLR_VAL && flags_o.timeout_flag_n
        && !flags_o.powerdown_flag_n && !osc_run_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_swap_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      exec_c && (s_q.ins.op inside {MCIS_OP_NIBBLE_EXCHANGE, MCIS_OP_LOAD_PORT_DIRECTION})
        |=> $stable({flags_o.carry, flags_o.half_carry_flag, flags_o.zero,
                     flags_o.powerdown_flag_n})
            && ($stable(flags_o.timeout_flag_n) || $past(wdt_tick_i));
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("flags changed");

  property p_xor_lit;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      s_exec(MCIS_OP_XOR_LITERAL_ACC) |=> acc_o == ($past(s_q.acc) ^ $past(s_q.ins.literal))
        && flags_o.zero == (acc_o == 8'h00) && flags_o.carry == $past(flags_o.carry);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

  property p_dir_b;
    @(posedge clk_sys_i) disable iff (!rst_n_q)
      s_exec_addr(MCIS_OP_LOAD_PORT_DIRECTION, {4'h0, DIR_SEL_B}) |=>
        dirs_o.port_b_direction == $past(acc_o);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("direction load wrong");

endmodule : mcis_core

// ===== testbench/tb_mcu_core_instruction_subset.sv
// Self-checking random testbench of the instruction subset core
`timescale 1ns/10ps
module tb_mcu_core_instruction_subset;
  import mcis_pkg::*;

  logic        clk_sys_i;
  logic        arst_n_i;
  mcis_instr_t instr_i;
  logic        instr_rdy_o;
  logic        wake_i;
  logic        wdt_tick_i;
  logic [7:0]  acc_o;
  mcis_flags_t flags_o;
  mcis_dirs_t  dirs_o;
  logic [7:0]  wdt_count_o;
  logic        osc_run_o;
  logic        done_o;
  int          errors;
  int          comparisons;
  logic [7:0]  m_acc;
  mcis_flags_t m_flg;
  mcis_dirs_t  m_dir;
  logic [7:0]  m_mem [FILE_DEPTH];
  logic [6:0]  addrs [4] = '{7'h00, 7'h40, 7'h7E, 7'h7F};
  mcis_op_t    ops [8] = '{MCIS_OP_NOP, MCIS_OP_ROTATE_RIGHT_VIA_CARRY,
    MCIS_OP_LITERAL_MINUS_ACC, MCIS_OP_FILE_MINUS_ACC, MCIS_OP_FILE_MINUS_ACC_BORROW,
    MCIS_OP_NIBBLE_EXCHANGE, MCIS_OP_XOR_LITERAL_ACC, MCIS_OP_XOR_ACC_FILE};

  mcis_core dut (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .instr_i     (instr_i),
    .instr_rdy_o (instr_rdy_o),
    .wake_i      (wake_i),
    .wdt_tick_i  (wdt_tick_i),
    .acc_o       (acc_o),
    .flags_o     (flags_o),
    .dirs_o      (dirs_o),
    .wdt_count_o (wdt_count_o),
    .osc_run_o   (osc_run_o),
    .done_o      (done_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // Checking and reference model
  // ----------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : chk

  // Returns {no_borrow, half_no_borrow, difference}
  function automatic logic [9:0] sub(input logic [7:0] a, input logic [7:0] b, input logic bin);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    return {~d[8], ~h[4], d[7:0]};
  endfunction : sub

  task automatic predict(input mcis_op_t op, input logic [6:0] a, input logic d,
                         input logic [7:0] k);
    logic [7:0] f;
    logic [7:0] r;
    f = m_mem[a];
    r = m_acc;
    case (op)
      MCIS_OP_ROTATE_RIGHT_VIA_CARRY: begin
        r = {m_flg.carry, f[7:1]};
        m_flg.carry = f[0];
      end
      MCIS_OP_LITERAL_MINUS_ACC, MCIS_OP_FILE_MINUS_ACC, MCIS_OP_FILE_MINUS_ACC_BORROW: begin
        {m_flg.carry, m_flg.half_carry_flag, r} = sub(
          (op == MCIS_OP_LITERAL_MINUS_ACC) ? k : f, m_acc,
          (op == MCIS_OP_FILE_MINUS_ACC_BORROW) ? ~m_flg.carry : 1'b0);
        m_flg.zero = (r == 8'h00);
      end
      MCIS_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
      MCIS_OP_XOR_LITERAL_ACC, MCIS_OP_XOR_ACC_FILE: begin
        r = m_acc ^ ((op == MCIS_OP_XOR_LITERAL_ACC) ? k : f);
        m_flg.zero = (r == 8'h00);
      end
      MCIS_OP_LOAD_PORT_DIRECTION: begin
        if (a == 7'h05) m_dir.port_a_direction = m_acc;
        if (a == 7'h06) m_dir.port_b_direction = m_acc;
        if (a == 7'h07) m_dir.port_c_direction = m_acc;
      end
      MCIS_OP_SLEEP: begin
        m_flg.timeout_flag_n = TO_N_SLEEP;
        m_flg.powerdown_flag_n = PD_N_SLEEP;
      end
      default: ;
    endcase
    if (op inside {MCIS_OP_LITERAL_MINUS_ACC, MCIS_OP_XOR_LITERAL_ACC}) begin
      m_acc = r;
    end else if (op inside {MCIS_OP_ROTATE_RIGHT_VIA_CARRY, MCIS_OP_FILE_MINUS_ACC,
        MCIS_OP_FILE_MINUS_ACC_BORROW, MCIS_OP_NIBBLE_EXCHANGE, MCIS_OP_XOR_ACC_FILE}) begin
      if (d == DEST_FILE) m_mem[a] = r;
      else m_acc = r;
    end
  endtask : predict

  // ----------------------------------------
  // Instruction driver
  // ----------------------------------------
  task automatic run(input mcis_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
    @(posedge clk_sys_i);
    instr_i <= '{valid: 1'b1, op: op, addr: a, dest: d, literal: k};
    @(posedge clk_sys_i);
    instr_i.valid <= 1'b0;
    predict(op, a, d, k);
    #1;
    for (int i = 0; i < 8 && done_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(24'(done_o), 24'h000001, "done");
    chk(24'(acc_o), 24'(m_acc), "acc");
    chk(24'(flags_o), 24'(m_flg), "flags");
    chk(dirs_o, m_dir, "dirs");
  endtask : run

  // Swaps a file register into the accumulator; checks its cleared state
  task automatic learn(input logic [6:0] a);
    run(MCIS_OP_NIBBLE_EXCHANGE, a, DEST_ACC, 8'h00);
  endtask : learn

  task automatic results();
    $display("Summary: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [6:0] a;
    errors = 0;
    comparisons = 0;
    arst_n_i = 1'b0;
    instr_i = '0;
    wake_i = 1'b0;
    wdt_tick_i = 1'b0;
    m_acc = ACC_RST;
    m_flg = '{1'b0, 1'b0, 1'b0, TO_N_RST, PD_N_RST};
    m_dir = {3{DIR_RST}};
    foreach (m_mem[i]) m_mem[i] = FILE_RST;
    void'($urandom(500));
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(24'(flags_o), 24'(m_flg), "reset flags");
    chk(dirs_o, m_dir, "reset dirs");
    $display("Test reset done");
    foreach (addrs[i]) learn(addrs[i]);
    run(MCIS_OP_XOR_LITERAL_ACC, 7'h00, 1'b0, m_acc);
    run(MCIS_OP_LITERAL_MINUS_ACC, 7'h00, 1'b0, 8'h00);
    run(MCIS_OP_XOR_LITERAL_ACC, 7'h00, 1'b0, 8'h5A);
    run(MCIS_OP_LITERAL_MINUS_ACC, 7'h00, 1'b0, 8'h59);
    run(MCIS_OP_FILE_MINUS_ACC_BORROW, 7'h40, DEST_FILE, 8'h00);
    run(MCIS_OP_XOR_LITERAL_ACC, 7'h00, 1'b0, 8'hC3);
    for (int i = 3; i < 9; i++) run(MCIS_OP_LOAD_PORT_DIRECTION, 7'(i), 1'b0, 8'h00);
    run(MCIS_OP_LOAD_PORT_DIRECTION, 7'h0D, 1'b0, 8'h00);
    $display("Test corner cases done");
    for (int n = 0; n < 200; n++) begin
      mcis_op_t op;
      op = ops[$urandom_range(0, 7)];
      a = addrs[$urandom_range(0, 3)];
      run(op, a, 1'($urandom), 8'($urandom));
      if (n % 20 == 0) run(MCIS_OP_LOAD_PORT_DIRECTION, 7'($urandom_range(4, 8)), 1'b0, 8'h00);
    end
    $display("Test random instructions done");
    @(posedge clk_sys_i);
    wdt_tick_i <= 1'b1;
    repeat (256) @(posedge clk_sys_i);
    wdt_tick_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    m_flg.timeout_flag_n = WDT_TIMEOUT_N;
    chk(24'(flags_o), 24'(m_flg), "overflow flags");
    repeat (7) @(posedge clk_sys_i);
    wdt_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_tick_i <= 1'b0;
    run(MCIS_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    chk(24'(wdt_count_o), 24'(WDT_CLR_VAL), "wdt");
    chk(24'(osc_run_o), 24'h000000, "osc");
    @(posedge clk_sys_i);
    instr_i <= '{valid: 1'b1, op: MCIS_OP_XOR_LITERAL_ACC, addr: 7'h00, dest: 1'b0,
                 literal: 8'hFF};
    repeat (4) @(posedge clk_sys_i);
    instr_i.valid <= 1'b0;
    #1;
    chk(24'(acc_o), 24'(m_acc), "asleep acc");
    chk(24'(instr_rdy_o), 24'h000000, "asleep rdy");
    wake_i <= 1'b1;
    for (int i = 0; i < 10 && instr_rdy_o !== 1'b1; i++) @(posedge clk_sys_i);
    wake_i <= 1'b0;
    #1;
    chk(24'(osc_run_o), 24'h000001, "woken osc");
    run(MCIS_OP_XOR_LITERAL_ACC, 7'h00, 1'b0, 8'hC3);
    $display("Test sleep done");
    results();
  end

endmodule : tb_mcu_core_instruction_subset
